// File: acdma_pkg.sv
// Package of constants and types for the converter DMA buffer interface
// Behaviour
// - A read of the vector base register returns the written base plus the ready channel ID shifted left by the vector shift amount.
// - The channel ID used for the vector is the lowest-numbered channel whose ready flag is set.
// - While the DMA interface enable is clear, its logic is held in reset, nothing is buffered and no SRAM write happens.
// - The overflow error flag is set by hardware on a DMA buffer overflow and cleared after software reads the status register.
// - On overflow the newer sample replaces the unwritten older one and is still written.
// - The buffer B full flag of channel 0 sits at bit 16 and clears when software reads it.
// - The buffer A full flag of channel 0 sits at bit 0 and clears when software reads it.
// - With the buffer B full interrupt enable at bit 24 and mask bit IRQ_BFULL both set, a buffer B full event raises the interrupt; otherwise it does not.
// - With the buffer A full interrupt enable at bit 8 and mask bit IRQ_AFULL both set, a buffer A full event raises the interrupt; otherwise it does not.
// - With the count store enable at bit 15 set, the current buffer's count is written to the count table after each sample write.
// - Each sample of channel x into buffer z increments a one-byte counter at count base plus 2x plus z.
// - The buffer index is 0 while a channel writes buffer A and 1 for buffer B, kept per channel.
// - Count bytes are written to SRAM only while the count store enable is set.
// - The count base is a full 32-bit SRAM address.
// - A sample is stored as two bytes at data base plus (2x+z) times 2 to the (length exponent + 1) plus twice the count.
package acdma_pkg;

   localparam int ACDMA_NCHAN_DEF = 7;

   // Register byte offsets
   localparam logic [11:0] OFF_VECBASE = 12'h000;
   localparam logic [11:0] OFF_DMASTAT = 12'h004;
   localparam logic [11:0] OFF_CNTBASE = 12'h008;
   localparam logic [11:0] OFF_DATABASE = 12'h00C;
   localparam logic [11:0] OFF_CONFIG = 12'h010;
   localparam logic [11:0] OFF_IRQSTAT = 12'h014;
   localparam logic [11:0] OFF_IRQMASK = 12'h018;

   // Status and control word fields
   localparam int BIT_DMA_ON = 31;
   localparam int BIT_BFULL_IEN = 24;
   localparam int BIT_OVF = 23;
   localparam int BIT_BFULL = 16;
   localparam int BIT_CNT_ON = 15;
   localparam int BIT_AFULL_IEN = 8;
   localparam int BIT_AFULL = 0;

   // Configuration word fields, three bits each
   localparam int CFG_SHIFT_LSB = 0;
   localparam int CFG_BLEN_LSB = 8;

   // Interrupt status and mask bits
   localparam int IRQ_AFULL = 0;
   localparam int IRQ_BFULL = 1;
   localparam int IRQ_OVF = 2;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_CNT = 2'b10
   } acdma_state_t;

   typedef struct packed {
      logic [2:0] chan;
      logic [15:0] data;
   } acdma_smp_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] data;
      logic byteWr;
   } acdma_mem_t;

endpackage : acdma_pkg

// File: acdma_top.sv
// Converter DMA buffer interface: APB registers, ping-pong SRAM writer, vector base
//
// The implementer's own choices: the APB register port and the placing of the registers.
module acdma_top
   import acdma_pkg::*;
#(
   parameter int NCHAN = ACDMA_NCHAN_DEF
) (
   input wire logic clk_sys, // System clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic [6:0] chanReady, // Channel ready flags
   input wire logic smpValid, // New sample strobe
   input wire acdma_smp_t smpIn, // Channel and sample
   output logic memReq, // SRAM write request, held until memAck
   output acdma_mem_t memOut, // SRAM write address, data, size
   input wire logic memAck, // SRAM write accepted
   output logic irq // Interrupt, level
);

   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic irq_ff;
   logic memReq_ff;
   acdma_mem_t memOut_ff;

   logic [15:0] vecBase_ff;
   logic dmaOn_ff;
   logic bIen_ff;
   logic aIen_ff;
   logic cntOn_ff;
   logic ovf_ff;
   logic bFull_ff;
   logic aFull_ff;
   logic [31:0] cntBase_ff;
   logic [31:0] dataBase_ff;
   logic [2:0] vecShift_ff;
   logic [2:0] bufLenExp_ff;
   logic [2:0] irqStat_ff;
   logic [2:0] irqMask_ff;

   acdma_state_t state_ff;
   acdma_smp_t pend_ff;
   logic pendValid_ff;
   acdma_smp_t cur_ff;
   logic curZ_ff;
   logic [NCHAN-1:0][7:0] count_ff;
   logic [NCHAN-1:0] bufSel_ff;

   logic apbAcc;
   logic apbWr;
   logic apbRd;
   logic mapped;
   logic [31:0] rdMux;
   logic rdDmaStat;
   logic rdIrqStat;
   logic [2:0] lowId;
   logic [15:0] vecRead;
   logic smpOk;
   logic take;
   logic ovfEvt;
   logic dataDone;
   logic [7:0] nextCount;
   logic wrap;
   logic aFullEvt;
   logic bFullEvt;

   function automatic logic [31:0] dataAddr(input logic [31:0] base, input logic [2:0] x,
                                           input logic z, input logic [2:0] bl,
                                           input logic [7:0] y);
      logic [31:0] slot;
      slot = {28'h0, x, z} << (4'(bl) + 4'h1);
      return base + slot + {23'h0, y, 1'b0};
   endfunction : dataAddr

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign memReq = memReq_ff;
   assign memOut = memOut_ff;

   // APB decode; every access answers one cycle into its access phase
   assign apbAcc = psel & penable & ~pready_ff;
   assign apbWr = apbAcc & pwrite;
   assign apbRd = apbAcc & ~pwrite;
   assign rdDmaStat = apbRd && (paddr == OFF_DMASTAT);
   assign rdIrqStat = apbRd && (paddr == OFF_IRQSTAT);

   always_comb begin
      lowId = 3'h0;
      for (int i = 6; i >= 0; i--) begin
         if (chanReady[i]) begin
            lowId = 3'(i);
         end
      end
   end

   assign vecRead = vecBase_ff + 16'({13'h0, lowId} << vecShift_ff);

   always_comb begin
      rdMux = RST_WORD;
      mapped = 1'b1;
      case (paddr)
         OFF_VECBASE: begin
            rdMux = {16'h0, vecRead};
         end
         OFF_DMASTAT: begin
            rdMux[BIT_DMA_ON] = dmaOn_ff;
            rdMux[BIT_BFULL_IEN] = bIen_ff;
            rdMux[BIT_OVF] = ovf_ff;
            rdMux[BIT_BFULL] = bFull_ff;
            rdMux[BIT_CNT_ON] = cntOn_ff;
            rdMux[BIT_AFULL_IEN] = aIen_ff;
            rdMux[BIT_AFULL] = aFull_ff;
         end
         OFF_CNTBASE: begin
            rdMux = cntBase_ff;
         end
         OFF_DATABASE: begin
            rdMux = dataBase_ff;
         end
         OFF_CONFIG: begin
            rdMux[CFG_SHIFT_LSB +: 3] = vecShift_ff;
            rdMux[CFG_BLEN_LSB +: 3] = bufLenExp_ff;
         end
         OFF_IRQSTAT: begin
            rdMux = {29'h0, irqStat_ff};
         end
         OFF_IRQMASK: begin
            rdMux = {29'h0, irqMask_ff};
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= RST_WORD;
      end else begin
         pready_ff <= apbAcc;
         pslverr_ff <= apbAcc & ~mapped;
         if (apbRd) begin
            prdata_ff <= rdMux;
         end else if (apbAcc) begin
            prdata_ff <= RST_WORD;
         end
      end
   end

   // Software-written control
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vecBase_ff <= RST_WORD[15:0];
         dmaOn_ff <= 1'b0;
         bIen_ff <= 1'b0;
         aIen_ff <= 1'b0;
         cntOn_ff <= 1'b0;
         cntBase_ff <= RST_WORD;
         dataBase_ff <= RST_WORD;
         vecShift_ff <= RST_WORD[2:0];
         bufLenExp_ff <= RST_WORD[2:0];
         irqMask_ff <= RST_WORD[2:0];
      end else if (apbWr) begin
         case (paddr)
            OFF_VECBASE: begin
               vecBase_ff <= pwdata[15:0];
            end
            OFF_DMASTAT: begin
               dmaOn_ff <= pwdata[BIT_DMA_ON];
               bIen_ff <= pwdata[BIT_BFULL_IEN];
               cntOn_ff <= pwdata[BIT_CNT_ON];
               aIen_ff <= pwdata[BIT_AFULL_IEN];
            end
            OFF_CNTBASE: begin
               cntBase_ff <= pwdata;
            end
            OFF_DATABASE: begin
               dataBase_ff <= pwdata;
            end
            OFF_CONFIG: begin
               vecShift_ff <= pwdata[CFG_SHIFT_LSB +: 3];
               bufLenExp_ff <= pwdata[CFG_BLEN_LSB +: 3];
            end
            OFF_IRQMASK: begin
               irqMask_ff <= pwdata[2:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Hardware flags: a set in the same cycle as the clearing read wins
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ovf_ff <= 1'b0;
         bFull_ff <= 1'b0;
         aFull_ff <= 1'b0;
      end else begin
         ovf_ff <= ovfEvt | (ovf_ff & ~rdDmaStat);
         bFull_ff <= bFullEvt | (bFull_ff & ~rdDmaStat);
         aFull_ff <= aFullEvt | (aFull_ff & ~rdDmaStat);
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqStat_ff <= RST_WORD[2:0];
         irq_ff <= 1'b0;
      end else begin
         irqStat_ff <= {ovfEvt, bFullEvt, aFullEvt} | (irqStat_ff & ~{3{rdIrqStat}});
         // Full events also need their own enable in the status word
         irq_ff <= |(irqStat_ff & irqMask_ff & {1'b1, bIen_ff, aIen_ff});
      end
   end

   // One-sample holding stage ahead of the SRAM writer
   assign smpOk = smpValid && (int'(smpIn.chan) < NCHAN) && dmaOn_ff;
   assign take = (state_ff == ST_IDLE) && pendValid_ff;
   assign ovfEvt = smpOk && pendValid_ff && !take;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pendValid_ff <= 1'b0;
         pend_ff <= '0;
      end else if (!dmaOn_ff) begin
         pendValid_ff <= 1'b0;
      end else if (smpOk) begin
         pend_ff <= smpIn;
         pendValid_ff <= 1'b1;
      end else if (take) begin
         pendValid_ff <= 1'b0;
      end
   end

   assign dataDone = (state_ff == ST_DATA) && memAck;
   assign nextCount = count_ff[cur_ff.chan] + 8'h01;
   assign wrap = nextCount == 8'(8'h01 << bufLenExp_ff);
   assign aFullEvt = dataDone && wrap && (cur_ff.chan == 3'h0) && !curZ_ff;
   assign bFullEvt = dataDone && wrap && (cur_ff.chan == 3'h0) && curZ_ff;

   // Per-channel sample count and buffer index
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count_ff <= '0;
         bufSel_ff <= '0;
      end else if (!dmaOn_ff) begin
         count_ff <= '0;
         bufSel_ff <= '0;
      end else if (dataDone) begin
         if (wrap) begin
            count_ff[cur_ff.chan] <= 8'h00;
            bufSel_ff[cur_ff.chan] <= ~bufSel_ff[cur_ff.chan];
         end else begin
            count_ff[cur_ff.chan] <= nextCount;
         end
      end
   end

   // SRAM writer: sample halfword, then optional count byte
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         memReq_ff <= 1'b0;
         memOut_ff <= '0;
         cur_ff <= '0;
         curZ_ff <= 1'b0;
      end else if (!dmaOn_ff) begin
         // Disabling aborts a write in flight
         state_ff <= ST_IDLE;
         memReq_ff <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (take) begin
                  cur_ff <= pend_ff;
                  curZ_ff <= bufSel_ff[pend_ff.chan];
                  memReq_ff <= 1'b1;
                  memOut_ff.addr <= dataAddr(dataBase_ff, pend_ff.chan,
                                             bufSel_ff[pend_ff.chan], bufLenExp_ff,
                                             count_ff[pend_ff.chan]);
                  memOut_ff.data <= pend_ff.data;
                  memOut_ff.byteWr <= 1'b0;
                  state_ff <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (memAck) begin
                  if (cntOn_ff) begin
                     memOut_ff.addr <= cntBase_ff + {28'h0, cur_ff.chan, 1'b0}
                                       + {31'h0, curZ_ff};
                     memOut_ff.data <= {8'h00, nextCount};
                     memOut_ff.byteWr <= 1'b1;
                     state_ff <= ST_CNT;
                  end else begin
                     memReq_ff <= 1'b0;
                     state_ff <= ST_IDLE;
                  end
               end
            end
            ST_CNT: begin
               if (memAck) begin
                  memReq_ff <= 1'b0;
                  state_ff <= ST_IDLE;
               end
            end
            default: begin
               memReq_ff <= 1'b0;
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   vec_base_read_a: assert property (
      apbRd && paddr == OFF_VECBASE && chanReady == 7'h00
      |=> prdata_ff == {16'h0, $past(vecBase_ff)})
      else $error("vector base read differs from written base");

   vec_prio_pick_a: assert property (
      apbRd && paddr == OFF_VECBASE && chanReady[1:0] == 2'b10 && vecShift_ff == 3'h1
      |=> prdata_ff[15:0] == $past(vecBase_ff) + 16'h0002)
      else $error("vector does not use lowest ready channel");

   dma_off_quiet_a: assert property (
      !dmaOn_ff |=> !memReq_ff && !pendValid_ff && count_ff == '0)
      else $error("interface active while disabled");

   ovf_flag_set_a: assert property (
      ovfEvt |=> ovf_ff ##1 (ovf_ff || $past(rdDmaStat)))
      else $error("overflow flag not set");

   ovf_read_clear_a: assert property (
      rdDmaStat && !ovfEvt |=> !ovf_ff && prdata_ff[BIT_OVF] == $past(ovf_ff))
      else $error("overflow flag not cleared by read");

   ovf_newest_kept_a: assert property (
      ovfEvt |=> pendValid_ff && pend_ff == $past(smpIn))
      else $error("newer sample not kept on overflow");

   bfull_clear_a: assert property (
      rdDmaStat && !bFullEvt && bFull_ff |=> prdata_ff[16] && !bFull_ff)
      else $error("buffer B full flag wrong on read");

   afull_clear_a: assert property (
      rdDmaStat && !aFullEvt && aFull_ff |=> prdata_ff[0] && !aFull_ff)
      else $error("buffer A full flag wrong on read");

   bfull_irq_a: assert property (
      bFullEvt && bIen_ff && irqMask_ff[IRQ_BFULL] && !rdIrqStat
      ##1 bIen_ff && irqMask_ff[IRQ_BFULL] |=> irq_ff)
      else $error("buffer B full interrupt missing");

   afull_irq_off_a: assert property (
      !aIen_ff && !irqStat_ff[IRQ_OVF] && !irqStat_ff[IRQ_BFULL] |=> !irq_ff)
      else $error("buffer A full interrupt while disabled");

   cnt_store_a: assert property (
      dataDone && cntOn_ff && dmaOn_ff |=> state_ff == ST_CNT && memReq_ff && memOut_ff.byteWr)
      else $error("count byte write missing");

   cnt_addr_a: assert property (
      state_ff == ST_CNT |-> memOut_ff.addr - cntBase_ff == {28'h0, cur_ff.chan, curZ_ff}
      && memOut_ff.data[7:0] != 8'h00)
      else $error("count byte address or value wrong");

   cnt_gate_a: assert property (
      dataDone && !cntOn_ff && dmaOn_ff |=> state_ff == ST_IDLE && !memReq_ff)
      else $error("count written while store disabled");

   data_addr_a: assert property (
      take && dmaOn_ff && pend_ff.chan == 3'h0 && bufSel_ff[0] == 1'b0 && count_ff[0] == 8'h00
      |=> memReq_ff && memOut_ff.addr == $past(dataBase_ff) && !memOut_ff.byteWr)
      else $error("first sample address wrong");

   buf_swap_a: assert property (
      dataDone && wrap && dmaOn_ff
      |=> bufSel_ff[$past(cur_ff.chan)] != $past(bufSel_ff[cur_ff.chan])
      && count_ff[$past(cur_ff.chan)] == 8'h00)
      else $error("buffer did not switch when full");

endmodule : acdma_top

// File: acdma_sram_model.sv
// SRAM partner model: accepts writes after a set stall and logs them
module acdma_sram_model
   import acdma_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rst, // Reset, active high
   input wire logic memReq, // Write request
   input wire acdma_mem_t memOut, // Write address and data
   input wire logic [3:0] stall, // Wait cycles before accepting
   output logic memAck // Write accepted
);
   timeunit 1ns;
   timeprecision 1ps;
   acdma_mem_t wrLog[$];
   logic [3:0] waitCnt_ff;
   // Ack drops after each accepted write, so a held request must wait again
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         memAck <= 1'b0;
         waitCnt_ff <= 4'h0;
      end else if (memReq && memAck) begin
         wrLog.push_back(memOut);
         memAck <= 1'b0;
         waitCnt_ff <= 4'h0;
      end else if (memReq && waitCnt_ff >= stall) begin
         memAck <= 1'b1;
      end else begin
         memAck <= 1'b0;
         waitCnt_ff <= memReq ? waitCnt_ff + 4'h1 : 4'h0;
      end
   end
endmodule : acdma_sram_model

// File: acdma_top_tb.sv
// Testbench for the converter DMA buffer interface
module acdma_top_tb;
   import acdma_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] DB = 32'h2000_0000;
   localparam logic [31:0] CB = 32'h3000_0100;
   int bl = 1;
   logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic smpValid = 1'b0, memReq, memAck, irq, pready, pslverr, rde;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic [6:0] chanReady = 7'h00;
   logic [3:0] stall = 4'h0;
   acdma_smp_t smpIn = '0;
   acdma_mem_t memOut;
   acdma_mem_t expQ[$];
   int errTotal = 0, compares = 0;
   int cnt[7] = '{default: 0};
   int zb[7] = '{default: 0};
   always #2 clk_sys = ~clk_sys;
   acdma_top i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chanReady(chanReady), .smpValid(smpValid), .smpIn(smpIn),
      .memReq(memReq), .memOut(memOut), .memAck(memAck), .irq(irq));
   acdma_sram_model i_sram (.clk_sys(clk_sys), .rst(rst), .memReq(memReq),
      .memOut(memOut), .stall(stall), .memAck(memAck));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdv = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so a following call never re-drives psel in this time step
      @(posedge clk_sys);
      if (n >= 50) chk(32'h0, 32'h1, "no pready");
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      apb(a, 1'b0, 32'h0);
   endtask : rd

   task automatic send(input logic [2:0] ch, input logic [15:0] d);
      smpValid <= 1'b1;
      smpIn <= '{chan: ch, data: d};
      @(posedge clk_sys);
      smpValid <= 1'b0;
   endtask : send

   // Idle means no request for four edges in a row
   task automatic drain();
      int q, n;
      q = 0;
      n = 0;
      while (q < 4 && n < 300) begin
         @(posedge clk_sys);
         n++;
         q = memReq ? 0 : q + 1;
      end
      if (n >= 300) chk(32'h0, 32'h1, "writer never idle");
   endtask : drain

   task automatic expect_smp(input int ch, input logic [15:0] d, input logic cntOn);
      logic [31:0] a;
      a = DB + 32'((2 * ch + zb[ch]) << (bl + 1)) + 32'(2 * cnt[ch]);
      expQ.push_back('{addr: a, data: d, byteWr: 1'b0});
      cnt[ch]++;
      if (cntOn) expQ.push_back('{addr: CB + 32'(2 * ch + zb[ch]), data: 16'(cnt[ch]), byteWr: 1'b1});
      if (cnt[ch] == 2 ** bl) begin
         cnt[ch] = 0;
         zb[ch] ^= 1;
      end
   endtask : expect_smp

   task automatic cmp_log();
      acdma_mem_t g, e;
      chk(32'(i_sram.wrLog.size()), 32'(expQ.size()), "write count");
      while (expQ.size() > 0 && i_sram.wrLog.size() > 0) begin
         e = expQ.pop_front();
         g = i_sram.wrLog.pop_front();
         chk(g.addr, e.addr, "address");
         chk(32'({g.byteWr, g.byteWr ? {8'h00, g.data[7:0]} : g.data}), 32'({e.byteWr, e.data}), "data");
      end
      expQ.delete();
      i_sram.wrLog.delete();
   endtask : cmp_log

   task automatic t_regs();
      logic [11:0] offs[7] = '{OFF_VECBASE, OFF_DMASTAT, OFF_CNTBASE, OFF_DATABASE,
         OFF_CONFIG, OFF_IRQSTAT, OFF_IRQMASK};
      foreach (offs[i]) begin
         rd(offs[i]);
         chk(rdv, RST_WORD, "reset value");
      end
      rd(12'h01C);
      chk({31'h0, rde}, 32'h1, "unmapped error");
      chk(rdv, 32'h0, "unmapped data");
      wr(OFF_CNTBASE, 32'hA5C3_F00D);
      rd(OFF_CNTBASE);
      chk(rdv, 32'hA5C3_F00D, "count base");
      wr(OFF_DMASTAT, 32'hFFFF_FFFF);
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8100_8100, "status write mask");
      wr(OFF_DMASTAT, 32'h0);
   endtask : t_regs

   task automatic t_vector();
      logic [6:0] pats[4] = '{7'h00, 7'h48, 7'h40, 7'h7E};
      int ids[4] = '{0, 3, 6, 1};
      wr(OFF_VECBASE, 32'h0000_FFF0);
      for (int s = 0; s < 8; s++) begin
         wr(OFF_CONFIG, 32'(s));
         for (int j = 0; j < 4; j++) begin
            chanReady <= pats[j];
            rd(OFF_VECBASE);
            chk(rdv, 32'(16'(16'hFFF0 + (ids[j] << s))), "vector");
         end
      end
      chanReady <= 7'h00;
   endtask : t_vector

   task automatic t_dmaoff();
      wr(OFF_CONFIG, 32'h0000_0100);
      wr(OFF_DATABASE, DB);
      wr(OFF_CNTBASE, CB);
      send(3'd2, 16'h1111);
      drain();
      cmp_log();
      wr(OFF_DMASTAT, 32'h8000_0000);
      send(3'd2, 16'h2222);
      expect_smp(2, 16'h2222, 1'b0);
      drain();
      stall <= 4'h8;
      send(3'd2, 16'h3333);
      wr(OFF_DMASTAT, 32'h0);
      drain();
      stall <= 4'h0;
      cnt[2] = 0;
      wr(OFF_DMASTAT, 32'h8000_0000);
      send(3'd2, 16'h4444);
      expect_smp(2, 16'h4444, 1'b0);
      drain();
      cmp_log();
   endtask : t_dmaoff

   task automatic t_stream();
      wr(OFF_IRQMASK, 32'h7);
      wr(OFF_DMASTAT, 32'h8100_8100);
      for (int i = 0; i < 2; i++) begin
         send(3'd0, 16'hA000 + 16'(i));
         expect_smp(0, 16'hA000 + 16'(i), 1'b1);
         drain();
      end
      cmp_log();
      chk({31'h0, irq}, 32'h1, "A full irq");
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8100_8101, "A full set");
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8100_8100, "A full cleared");
      rd(OFF_IRQSTAT);
      chk(rdv, 32'h1, "irq status A");
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      for (int i = 0; i < 4; i++) begin
         send(3'(5 * (i % 2)), 16'hB000 + 16'(i));
         expect_smp(5 * (i % 2), 16'hB000 + 16'(i), 1'b1);
         drain();
      end
      cmp_log();
      chk({31'h0, irq}, 32'h1, "B full irq");
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8101_8100, "B full set");
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8100_8100, "B full cleared");
      rd(OFF_IRQSTAT);
      chk(rdv, 32'h2, "irq status B");
      wr(OFF_DMASTAT, 32'h8000_0000);
      for (int i = 0; i < 2; i++) begin
         send(3'd0, 16'hC000 + 16'(i));
         expect_smp(0, 16'hC000 + 16'(i), 1'b0);
         drain();
      end
      cmp_log();
      chk({31'h0, irq}, 32'h0, "disabled irq");
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8000_0001, "flag without irq");
      rd(OFF_IRQSTAT);
      chk(rdv, 32'h1, "irq status without enable");
   endtask : t_stream

   task automatic t_ovf();
      stall <= 4'h6;
      send(3'd3, 16'h0001);
      repeat (3) @(posedge clk_sys);
      smpValid <= 1'b1;
      for (int i = 2; i < 4; i++) begin
         smpIn <= '{chan: 3'd3, data: 16'(i)};
         @(posedge clk_sys);
      end
      smpValid <= 1'b0;
      expect_smp(3, 16'h0001, 1'b0);
      expect_smp(3, 16'h0003, 1'b0);
      drain();
      stall <= 4'h0;
      cmp_log();
      chk({31'h0, irq}, 32'h1, "overflow irq");
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8080_0000, "overflow set");
      rd(OFF_DMASTAT);
      chk(rdv, 32'h8000_0000, "overflow cleared");
      rd(OFF_IRQSTAT);
      chk(rdv, 32'h4, "irq status overflow");
      // Longest buffer: slot stride needs the full shift of eight
      wr(OFF_CONFIG, 32'h0000_0700);
      bl = 7;
      send(3'd6, 16'h6666);
      expect_smp(6, 16'h6666, 1'b0);
      drain();
      cmp_log();
   endtask : t_ovf

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_regs();
      t_vector();
      t_dmaoff();
      t_stream();
      t_ovf();
      give_verdict();
   end

   // Tests need about 2000 ns; allow forty times that
   initial begin
      #80000;
      errTotal++;
      give_verdict();
   end
endmodule : acdma_top_tb
